// *** hdl/wec_wakeup_excitation_regs.sv ***
// Channel 2 wake-up control and excitation frequency configuration registers.
// Assumes a classic Wishbone master on REF_CLK and comparator flags synchronous to REF_CLK.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module wec_wakeup_excitation_regs
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        CH2_ABS_EXCEEDED,
  input  wire logic        CH2_RATE_EXCEEDED,
  output logic             CH2_ABSOLUTE_THRESHOLD_ENABLE,
  output logic             CH2_RATE_THRESHOLD_ENABLE,
  output logic             CH2_AND_OR_SELECT,
  output logic             CH2_WAKE,
  output logic      [5:0]  EXCITATION_LOW_LIMIT,
  output logic      [9:0]  EXCITATION_LOW_KHZ,
  output logic      [4:0]  EXCITATION_SPREAD_WIDTH,
  output logic      [9:0]  EXCITATION_SPREAD_KHZ,
  output logic             IRQ
);

  wec_reg_if                 bus ();

  wec_pkg::wec_regs_state_t  st;
  wec_pkg::wec_regs_state_t  next_st;

  logic                      abs_enable;
  logic                      rate_enable;
  logic                      and_select;
  logic                      wake_level;
  logic                      wake_pulse;
  logic                      abs_pulse;
  logic                      rate_pulse;
  logic [wec_pkg::EVT_W-1:0] events;
  logic [wec_pkg::EVT_W-1:0] clear_bits;
  logic                      wr_wake_ctrl;
  logic                      wr_low_limit;
  logic                      wr_spread;
  logic                      wr_status;
  logic                      wr_mask;
  logic [7:0]                read_value;

  wec_wb_slave u_slave
  (
    .clk      (REF_CLK),
    .rst      (RST),
    .wb_cyc   (WB_CYC_I),
    .wb_stb   (WB_STB_I),
    .wb_we    (WB_WE_I),
    .wb_adr   (WB_ADR_I),
    .wb_sel   (WB_SEL_I),
    .wb_dat_i (WB_DAT_I),
    .wb_dat_o (WB_DAT_O),
    .wb_ack   (WB_ACK_O),
    .regs     (bus.slave)
  );

  assign abs_enable  = st.wake_ctrl[wec_pkg::WU_ABS_EN_BIT];
  assign rate_enable = st.wake_ctrl[wec_pkg::WU_RATE_EN_BIT];
  assign and_select  = st.wake_ctrl[wec_pkg::WU_AND_SEL_BIT];

  // Software is expected to set both enables before choosing AND mode; the bank does not force them.
  wec_wake_detect u_detect
  (
    .clk        (REF_CLK),
    .rst        (RST),
    .abs_en     (abs_enable),
    .rate_en    (rate_enable),
    .and_sel    (and_select),
    .abs_over   (CH2_ABS_EXCEEDED),
    .rate_over  (CH2_RATE_EXCEEDED),
    .wake_level (wake_level),
    .wake_pulse (wake_pulse),
    .abs_pulse  (abs_pulse),
    .rate_pulse (rate_pulse)
  );

  always_comb
  begin
    events                    = '0;
    events[wec_pkg::EVT_WAKE] = wake_pulse;
    events[wec_pkg::EVT_ABS]  = abs_pulse;
    events[wec_pkg::EVT_RATE] = rate_pulse;
  end

  // Only the implemented low bits of each write are kept; the others fall away here.
  always_comb
  begin
    wr_wake_ctrl = 1'b0;
    wr_low_limit = 1'b0;
    wr_spread    = 1'b0;
    wr_status    = 1'b0;
    wr_mask      = 1'b0;
    if (bus.wr)
    begin
      unique case (bus.idx)
        wec_pkg::IDX_WAKE_CTRL:
        begin
          wr_wake_ctrl = 1'b1;
        end
        wec_pkg::IDX_LOW_LIMIT:
        begin
          wr_low_limit = 1'b1;
        end
        wec_pkg::IDX_SPREAD:
        begin
          wr_spread = 1'b1;
        end
        wec_pkg::IDX_IRQ_STATUS:
        begin
          wr_status = 1'b1;
        end
        wec_pkg::IDX_IRQ_MASK:
        begin
          wr_mask = 1'b1;
        end
        default:
        begin
          wr_status = 1'b0;
        end
      endcase
    end
  end

  assign clear_bits = wr_status ? bus.wdata[wec_pkg::EVT_W-1:0] : '0;

  always_comb
  begin
    next_st = st;

    if (wr_wake_ctrl)
    begin
      next_st.wake_ctrl = bus.wdata[wec_pkg::WU_W-1:0];
    end

    if (wr_low_limit)
    begin
      next_st.low_limit = bus.wdata[wec_pkg::LOW_W-1:0];
    end

    if (wr_spread)
    begin
      next_st.spread = bus.wdata[wec_pkg::SPREAD_W-1:0];
    end

    if (wr_mask)
    begin
      next_st.mask = bus.wdata[wec_pkg::EVT_W-1:0];
    end

    // An event in the same cycle as its write-one clear survives, so none is lost.
    next_st.status = (st.status & ~clear_bits) | events;

    next_st.wake = wake_level;
    next_st.irq  = |(next_st.status & next_st.mask);

    // Frequencies are held in flops so the analog side never sees a product settling.
    next_st.low_khz    = 10'(next_st.low_limit) * wec_pkg::LOW_STEP_KHZ;
    next_st.spread_khz = 10'(next_st.spread) * wec_pkg::SPREAD_STEP_KHZ;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      st.wake_ctrl  <= wec_pkg::WU_RESET;
      st.low_limit  <= wec_pkg::LOW_RESET;
      st.spread     <= wec_pkg::SPREAD_RESET;
      st.status     <= wec_pkg::STATUS_RESET;
      st.mask       <= wec_pkg::MASK_RESET;
      st.wake       <= 1'b0;
      st.irq        <= 1'b0;
      st.low_khz    <= 10'(wec_pkg::LOW_RESET) * wec_pkg::LOW_STEP_KHZ;
      st.spread_khz <= 10'(wec_pkg::SPREAD_RESET) * wec_pkg::SPREAD_STEP_KHZ;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    read_value = 8'h00;
    unique case (bus.idx)
      wec_pkg::IDX_WAKE_CTRL:
      begin
        read_value = {5'h00, st.wake_ctrl};
      end
      wec_pkg::IDX_LOW_LIMIT:
      begin
        read_value = {2'h0, st.low_limit};
      end
      wec_pkg::IDX_SPREAD:
      begin
        read_value = {3'h0, st.spread};
      end
      wec_pkg::IDX_IRQ_STATUS:
      begin
        read_value = {5'h00, st.status};
      end
      wec_pkg::IDX_IRQ_MASK:
      begin
        read_value = {5'h00, st.mask};
      end
      wec_pkg::IDX_LIVE:
      begin
        read_value = {5'h00, CH2_RATE_EXCEEDED, CH2_ABS_EXCEEDED, st.wake};
      end
      default:
      begin
        read_value = 8'h00;
      end
    endcase
  end

  assign bus.rdata = read_value;

  assign CH2_ABSOLUTE_THRESHOLD_ENABLE = abs_enable;
  assign CH2_RATE_THRESHOLD_ENABLE     = rate_enable;
  assign CH2_AND_OR_SELECT             = and_select;
  assign CH2_WAKE                      = st.wake;
  assign EXCITATION_LOW_LIMIT          = st.low_limit;
  assign EXCITATION_LOW_KHZ            = st.low_khz;
  assign EXCITATION_SPREAD_WIDTH       = st.spread;
  assign EXCITATION_SPREAD_KHZ         = st.spread_khz;
  assign IRQ                           = st.irq;

endmodule

`default_nettype wire

// *** common/wec_pkg.sv ***
// Shared constants and the register state type of the wake-up and excitation register bank.
// Assumes one 200 MHz clock and a synchronous, active high reset.
`default_nettype none

package wec_pkg;

  localparam int          ADR_W           = 8;
  localparam int          IDX_W           = 6;
  localparam int          WU_W            = 3;
  localparam int          LOW_W           = 6;
  localparam int          SPREAD_W        = 5;
  localparam int          EVT_W           = 3;
  localparam int          FREQ_W          = 10;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0]  IDX_WAKE_CTRL   = 6'h05;
  localparam logic [5:0]  IDX_LOW_LIMIT   = 6'h06;
  localparam logic [5:0]  IDX_SPREAD      = 6'h07;
  localparam logic [5:0]  IDX_IRQ_STATUS  = 6'h10;
  localparam logic [5:0]  IDX_IRQ_MASK    = 6'h11;
  localparam logic [5:0]  IDX_LIVE        = 6'h12;

  localparam int          WU_ABS_EN_BIT   = 0;
  localparam int          WU_RATE_EN_BIT  = 1;
  localparam int          WU_AND_SEL_BIT  = 2;

  localparam int          EVT_WAKE        = 0;
  localparam int          EVT_ABS         = 1;
  localparam int          EVT_RATE        = 2;

  localparam logic [2:0]  WU_RESET        = 3'h4;
  localparam logic [5:0]  LOW_RESET       = 6'h1e;
  localparam logic [4:0]  SPREAD_RESET    = 5'h00;
  localparam logic [2:0]  STATUS_RESET    = 3'h0;
  localparam logic [2:0]  MASK_RESET      = 3'h0;

  localparam logic [9:0]  LOW_STEP_KHZ    = 10'h00a;
  localparam logic [9:0]  SPREAD_STEP_KHZ = 10'h014;

  typedef struct packed {
    logic [WU_W-1:0]     wake_ctrl;
    logic [LOW_W-1:0]    low_limit;
    logic [SPREAD_W-1:0] spread;
    logic [EVT_W-1:0]    status;
    logic [EVT_W-1:0]    mask;
    logic                wake;
    logic                irq;
    logic [FREQ_W-1:0]   low_khz;
    logic [FREQ_W-1:0]   spread_khz;
  } wec_regs_state_t;

endpackage

`default_nettype wire

// *** common/wec_reg_if.sv ***
// Register access path between the bus slave and the register bank core.
// Assumes a write strobe that lasts exactly one clock cycle.
`timescale 1ns/1ps
`default_nettype none

interface wec_reg_if;
  logic       wr;
  logic [5:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave
  (
    output wr,
    output idx,
    output wdata,
    input  rdata
  );

  modport core
  (
    input  wr,
    input  idx,
    input  wdata,
    output rdata
  );
endinterface

`default_nettype wire

// *** hdl/wec_wb_slave.sv ***
// Classic Wishbone slave that turns bus cycles into one-cycle register accesses.
// Assumes the master holds its request until ack; every access is answered, unmapped ones with zero.
`timescale 1ns/1ps
`default_nettype none

module wec_wb_slave
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack,
  wec_reg_if.slave         regs
);

  typedef struct packed {
    logic       ack;
    logic [7:0] rdat;
  } wec_slave_state_t;

  wec_slave_state_t st;
  wec_slave_state_t next_st;
  logic             take;

  assign take = wb_cyc & wb_stb & ~st.ack;

  always_comb
  begin
    next_st     = st;
    next_st.ack = take;
    if (take)
    begin
      next_st.rdat = regs.rdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // The write lands on the edge at which the master sees ack, so an aborted cycle writes nothing.
  assign regs.wr    = wb_cyc & wb_stb & wb_we & st.ack & wb_sel[0];
  assign regs.idx   = wb_adr[7:2];
  assign regs.wdata = wb_dat_i[7:0];
  assign wb_dat_o   = {24'h000000, st.rdat};
  assign wb_ack     = st.ack;

endmodule

`default_nettype wire

// *** hdl/wec_wake_detect.sv ***
// Combines the channel 2 threshold comparator results into the wake-up condition.
// Assumes comparator flags synchronous to the clock; emits one-cycle pulses on rising conditions.
`timescale 1ns/1ps
`default_nettype none

module wec_wake_detect
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic abs_en,
  input  wire logic rate_en,
  input  wire logic and_sel,
  input  wire logic abs_over,
  input  wire logic rate_over,
  output logic      wake_level,
  output logic      wake_pulse,
  output logic      abs_pulse,
  output logic      rate_pulse
);

  typedef struct packed {
    logic wake;
    logic abs_hit;
    logic rate_hit;
  } wec_detect_state_t;

  wec_detect_state_t st;
  wec_detect_state_t next_st;
  logic              abs_hit;
  logic              rate_hit;

  assign abs_hit    = abs_en & abs_over;
  assign rate_hit   = rate_en & rate_over;
  // A disabled detection never counts, so AND mode with one detection off never wakes.
  assign wake_level = and_sel ? (abs_hit & rate_hit) : (abs_hit | rate_hit);

  always_comb
  begin
    next_st          = st;
    next_st.wake     = wake_level;
    next_st.abs_hit  = abs_hit;
    next_st.rate_hit = rate_hit;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wake_pulse = wake_level & ~st.wake;
  assign abs_pulse  = abs_hit & ~st.abs_hit;
  assign rate_pulse = rate_hit & ~st.rate_hit;

endmodule

`default_nettype wire

// *** sim/wec_regs_monitor.sv ***
// Concurrent checks on the ports of the wake-up and excitation register bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module wec_regs_monitor
(
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        CH2_ABS_EXCEEDED,
  input wire logic        CH2_RATE_EXCEEDED,
  input wire logic        CH2_ABSOLUTE_THRESHOLD_ENABLE,
  input wire logic        CH2_RATE_THRESHOLD_ENABLE,
  input wire logic        CH2_AND_OR_SELECT,
  input wire logic        CH2_WAKE,
  input wire logic [5:0]  EXCITATION_LOW_LIMIT,
  input wire logic [9:0]  EXCITATION_LOW_KHZ,
  input wire logic [4:0]  EXCITATION_SPREAD_WIDTH,
  input wire logic [9:0]  EXCITATION_SPREAD_KHZ,
  input wire logic        IRQ
);
  wire logic       a_hit = CH2_ABSOLUTE_THRESHOLD_ENABLE & CH2_ABS_EXCEEDED;
  wire logic       r_hit = CH2_RATE_THRESHOLD_ENABLE & CH2_RATE_EXCEEDED;
  wire logic       rd_ack = WB_ACK_O & ~WB_WE_I;
  wire logic [2:0] ctrl = {CH2_AND_OR_SELECT, CH2_RATE_THRESHOLD_ENABLE, CH2_ABSOLUTE_THRESHOLD_ENABLE};

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // Reset itself is the trigger here, so this one must not be disabled by it.
  reset_load_a: assert property (disable iff (1'b0) RST |=> ctrl == 3'h4 && EXCITATION_LOW_LIMIT == 6'h1e
    && EXCITATION_SPREAD_WIDTH == 5'h00 && !IRQ && !WB_ACK_O) else $error("Reset values wrong.");
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("Ack longer than one cycle.");
  ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("Request not answered in one cycle.");
  low_khz_a: assert property (EXCITATION_LOW_KHZ == 10'(EXCITATION_LOW_LIMIT) * 10'h00a)
    else $error("Low limit frequency wrong.");
  spread_khz_a: assert property (EXCITATION_SPREAD_KHZ == 10'(EXCITATION_SPREAD_WIDTH) * 10'h014)
    else $error("Spread frequency wrong.");
  and_wake_a: assert property (CH2_AND_OR_SELECT |=> CH2_WAKE == $past(a_hit & r_hit))
    else $error("Wake wrong in AND mode.");
  or_wake_a: assert property (!CH2_AND_OR_SELECT |=> CH2_WAKE == $past(a_hit | r_hit))
    else $error("Wake wrong in OR mode.");
  read_ctrl_a: assert property (rd_ack && WB_ADR_I == 8'h14 |-> WB_DAT_O == {29'h0, ctrl})
    else $error("Wake control readback wrong.");
  read_low_a: assert property (rd_ack && WB_ADR_I == 8'h18 |-> WB_DAT_O == {26'h0, EXCITATION_LOW_LIMIT})
    else $error("Low limit readback wrong.");
  read_spread_a: assert property (rd_ack && WB_ADR_I == 8'h1c |-> WB_DAT_O == {27'h0, EXCITATION_SPREAD_WIDTH})
    else $error("Spread readback wrong.");
endmodule

`default_nettype wire

// *** sim/wec_cpu_model.sv ***
// Processor core model: a classic Wishbone master doing single cycles.
// Assumes the slave answers every request; only the bench watchdog ends a wait.
`timescale 1ns/1ps
`default_nettype none

module wec_cpu_model
(
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [7:0]  adr,
  output logic      [3:0]  sel,
  output logic      [31:0] wdat
);
  initial {cyc, stb, we, adr, sel, wdat} = '0;

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the wake-up and excitation register bank.
// Assumes the processor model and the bound port monitor.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        abs_x = 1'b0;
  logic        rate_x = 1'b0;
  logic        cyc, stb, we, ack, en_a, en_r, and_sel, wake, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, dat_o, q, d;
  logic [5:0]  low;
  logic [4:0]  spread;
  logic [9:0]  low_khz, spread_khz;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          seed = 32'ha4824ceb;
  logic [2:0]  c;
  int          i;

  always #2.5 clk = ~clk;

  wec_cpu_model wec_cpu_model_inst (.clk(clk), .ack(ack), .rdat(dat_o), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .wdat(wdat));

  wec_wakeup_excitation_regs wec_wakeup_excitation_regs_inst (.REF_CLK(clk), .RST(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CH2_ABS_EXCEEDED(abs_x), .CH2_RATE_EXCEEDED(rate_x),
    .CH2_ABSOLUTE_THRESHOLD_ENABLE(en_a), .CH2_RATE_THRESHOLD_ENABLE(en_r), .CH2_AND_OR_SELECT(and_sel),
    .CH2_WAKE(wake), .EXCITATION_LOW_LIMIT(low), .EXCITATION_LOW_KHZ(low_khz),
    .EXCITATION_SPREAD_WIDTH(spread), .EXCITATION_SPREAD_KHZ(spread_khz), .IRQ(irq));

  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wec_cpu_model_inst.xfer(1'b1, a, v, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    wec_cpu_model_inst.xfer(1'b0, a, 32'h0, q);
    chk(e, q, nm);
  endtask

  // The interrupt line settles at the ack edge, so look one edge later.
  task automatic irqchk(input logic e);
    @(posedge clk);
    chk({31'h0, e}, {31'h0, irq}, "irq");
  endtask

  function automatic logic want_wake(input logic [2:0] c, input logic a, input logic r);
    return c[2] ? (a & c[0] & r & c[1]) : ((a & c[0]) | (r & c[1]));
  endfunction

  task report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h14, 32'h4, "wake ctrl reset");
    rdchk(8'h18, 32'h1e, "low limit reset");
    rdchk(8'h1c, 32'h0, "spread reset");
    chk(32'h12c, {22'h0, low_khz}, "low khz reset");
    for (i = 0; i < 12; i++)
    begin
      d = (i < 2) ? 32'hffffffff : $random(seed);
      wr(8'h18, d);
      rdchk(8'h18, {26'h0, d[5:0]}, "low limit");
      chk({26'h0, d[5:0]} * 32'ha, {22'h0, low_khz}, "low khz");
      wr(8'h1c, d);
      rdchk(8'h1c, {27'h0, d[4:0]}, "spread");
      chk({27'h0, d[4:0]} * 32'h14, {22'h0, spread_khz}, "spread khz");
      d = d | {30'h0, {2{d[2]}}};
      wr(8'h14, d);
      rdchk(8'h14, {29'h0, d[2:0]}, "wake ctrl");
      chk({29'h0, d[2:0]}, {29'h0, and_sel, en_r, en_a}, "ctrl pins");
    end
    rdchk(8'h20, 32'h0, "unmapped");
    // Software only selects AND mode with both detections enabled.
    for (i = 0; i < 32; i++)
    begin
      c = {i[4], i[3] | i[4], i[2] | i[4]};
      wr(8'h14, {29'h0, c});
      @(posedge clk);
      abs_x <= i[0];
      rate_x <= i[1];
      repeat (2) @(posedge clk);
      chk({31'h0, want_wake(c, i[0], i[1])}, {31'h0, wake}, "wake");
      abs_x <= 1'b0;
      rate_x <= 1'b0;
    end
    wr(8'h14, 32'h1);
    wr(8'h40, 32'h7);
    wr(8'h44, 32'h2);
    irqchk(1'b0);
    abs_x <= 1'b1;
    irqchk(1'b0);
    irqchk(1'b1);
    rdchk(8'h40, 32'h3, "irq status");
    rdchk(8'h48, 32'h3, "live");
    wr(8'h44, 32'h0);
    irqchk(1'b0);
    wr(8'h44, 32'h2);
    irqchk(1'b1);
    wr(8'h40, 32'h2);
    irqchk(1'b0);
    rdchk(8'h40, 32'h1, "status after clear");
    // A second reset in mid-run, with every register away from its reset value.
    abs_x <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h14, 32'h4, "wake ctrl reset again");
    rdchk(8'h18, 32'h1e, "low limit reset again");
    rdchk(8'h1c, 32'h0, "spread reset again");
    rdchk(8'h44, 32'h0, "mask reset again");
    chk(32'h12c, {22'h0, low_khz}, "low khz reset again");
    chk(32'h0, {22'h0, spread_khz}, "spread khz reset again");
    irqchk(1'b0);
    report_and_stop;
  end
endmodule

bind wec_wakeup_excitation_regs wec_regs_monitor wec_regs_monitor_inst (.*);

`default_nettype wire
